// file: src/spi_busy_pkg.sv
package spi_busy_pkg;

  // ---------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------
  localparam int HDR_BITS = 10;
  localparam int ADDR_BITS = 9;
  localparam int DATA_BITS = 16;
  localparam int WORD_BITS = HDR_BITS + DATA_BITS;

  typedef logic [4:0] cycles_t;
  typedef logic [1:0] gap_t;
  typedef logic [ADDR_BITS-1:0] addr_t;
  typedef logic [DATA_BITS-1:0] data_t;
  typedef logic [WORD_BITS-1:0] word_t;

  // ---------------------------------------------------------------
  // Timing counts, in serial clock rising edges
  // ---------------------------------------------------------------
  localparam cycles_t WORD_LEN = 5'h1a;
  localparam gap_t MIN_GAP_EDGES = 2'h3;
  localparam cycles_t BUSY_MIN = 5'h03;
  localparam cycles_t BUSY_MAX = 5'h1a;
  localparam cycles_t DAC_LEAD = 5'h04;
  localparam cycles_t DAC_MARK = DAC_LEAD + 5'h01;
  localparam cycles_t BIT_CNT_TOP = 5'h1f;

  // Default busy lengths per preceding instruction type
  localparam cycles_t BUSY_WRITE_DEF = 5'h0c;
  localparam cycles_t BUSY_READ_DEF = 5'h03;
  localparam cycles_t BUSY_RESET_DEF = 5'h08;

  // Serial word framing
  typedef enum logic {PH_IDLE, PH_SHIFT} phase_t;

endpackage : spi_busy_pkg

// file: src/busy_link_if.sv
interface busy_link_if;
  import spi_busy_pkg::*;

  logic tick;
  logic start;
  logic clear;
  logic isWrite;
  cycles_t len;
  logic busyN;
  logic dacStart;

  modport ctrl (output tick, output start, output clear, output isWrite, output len,
                input busyN, input dacStart);
  modport timer (input tick, input start, input clear, input isWrite, input len,
                 output busyN, output dacStart);

endinterface : busy_link_if

// file: src/busy_timer.sv
module busy_timer
  import spi_busy_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  busy_link_if.timer link
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic busyN;
    logic dacStart;
    logic isWrite;
    cycles_t cnt;
  } timer_t;

  localparam timer_t TIMER_RESET = '{busyN: 1'h1, dacStart: 1'h0, isWrite: 1'h0, cnt: 5'h00};

  timer_t s;
  timer_t next_s;

  // Busy countdown, advanced only by serial clock edges
  always_comb
  begin
    next_s = s;
    next_s.dacStart = 1'h0;
    if (link.clear)
    begin
      next_s = TIMER_RESET;
    end
    else if (link.tick)
    begin
      if (!s.busyN)
      begin
        if (s.cnt == 5'h01)
        begin
          next_s.busyN = 1'h1;
        end
        if (s.isWrite && s.cnt == DAC_MARK)
        begin
          next_s.dacStart = 1'h1;
        end
        next_s.cnt = s.cnt - 5'h01;
      end
      else if (link.start)
      begin
        next_s.busyN = 1'h0;
        next_s.cnt = link.len;
        next_s.isWrite = link.isWrite;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= TIMER_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign link.busyN = s.busyN;
  assign link.dacStart = s.dacStart;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_release_on_tick: assert property ($rose(s.busyN) |-> $past(link.tick) || $past(link.clear))
    else $error("busy released without a serial clock edge");
  a_busy_len_range: assert property (link.tick && link.start && s.busyN && !link.clear
      |-> link.len >= BUSY_MIN && link.len <= BUSY_MAX)
    else $error("busy length out of range");
  a_dac_lead_four: assert property (s.dacStart |-> s.cnt == DAC_LEAD && !s.busyN)
    else $error("converter update not four edges before busy release");
  a_busy_start_len: assert property (link.tick && link.start && s.busyN && !link.clear
      |=> !s.busyN && s.cnt == $past(link.len))
    else $error("busy period not loaded with its length");

  c_dac_update: cover property (s.dacStart);
  c_busy_done: cover property ($rose(s.busyN));

endmodule : busy_timer

// file: src/serial_port_busy_handshake.sv
// Functional notes
// - Busy asserts on first rising edge after valid release or reset release.
// - Busy lasts 3 to 26 cycles, length fixed by preceding instruction type.
// - Busy releases on a rising serial clock edge after its count.
// - Converter update starts four cycles before busy release, after writes.
// - Serial output is high impedance unless chip select is asserted.
// - Serial input is sampled on the rising serial clock edge.
// - Each new serial output bit launches from the rising edge.
// - Reset acts on assertion; release is recognised at a rising edge.
// - Readout returns read/write low, then 9 echoed header bits, then 16 data.
module serial_port_busy_handshake
  import spi_busy_pkg::*;
#(
  parameter cycles_t BUSY_WRITE_LEN = BUSY_WRITE_DEF,
  parameter cycles_t BUSY_READ_LEN = BUSY_READ_DEF,
  parameter cycles_t BUSY_RESET_LEN = BUSY_RESET_DEF
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi,
  input wire logic async_reset_n,
  input wire data_t rdData,
  output logic sdo,
  output logic sdoEn,
  output logic busyN,
  output logic dacUpdate,
  output logic wrStrobe,
  output addr_t wrAddr,
  output data_t wrData,
  output addr_t rdAddr
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sclkS;
    logic [1:0] csS;
    logic [1:0] sdiS;
    logic [1:0] rstS;
    phase_t phase;
    cycles_t bitCnt;
    gap_t gapCnt;
    logic frameOk;
    word_t inShift;
    word_t outShift;
    logic sdo;
    logic sdoEn;
    addr_t rdHdr;
    logic wrStrobe;
    addr_t wrAddr;
    data_t wrData;
    logic pendStart;
    logic pendWrite;
    cycles_t pendLen;
  } port_t;

  // Edge detector starts all ones, so a clock pin idling high gives no false rise
  localparam port_t PORT_RESET = '{
    sclkS: 3'h7, csS: 2'h3, sdiS: 2'h0, rstS: 2'h0, phase: PH_IDLE,
    bitCnt: 5'h00, gapCnt: MIN_GAP_EDGES, frameOk: 1'h0, inShift: '0, outShift: '0,
    sdo: 1'h0, sdoEn: 1'h0, rdHdr: '0, wrStrobe: 1'h0, wrAddr: '0, wrData: '0,
    pendStart: 1'h1, pendWrite: 1'h0, pendLen: BUSY_RESET_LEN};

  port_t s;
  port_t next_s;
  logic rise;
  logic csHigh;
  logic portUp;

  busy_link_if link ();

  busy_timer u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .link(link.timer)
  );

  // Synchronised pin views
  assign rise = s.sclkS[1] & ~s.sclkS[2];
  assign csHigh = s.csS[1];
  assign portUp = s.rstS[1];

  // Busy timer requests
  assign link.tick = rise;
  assign link.start = s.pendStart & portUp;
  assign link.clear = ~portUp;
  assign link.len = s.pendLen;
  assign link.isWrite = s.pendWrite;

  // ---------------------------------------------------------------
  // Framing, shifting and busy scheduling
  // ---------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.sclkS = {s.sclkS[1:0], sclk};
    next_s.csS = {s.csS[0], csN};
    next_s.sdiS = {s.sdiS[0], sdi};
    next_s.rstS = {s.rstS[0], async_reset_n};
    next_s.wrStrobe = 1'h0;
    // Pending busy start is consumed by the first edge the timer accepts
    if (rise && s.pendStart && portUp && link.busyN)
    begin
      next_s.pendStart = 1'h0;
    end
    if (!portUp)
    begin
      // Port reset held: abandon any frame, schedule a busy period
      next_s.phase = PH_IDLE;
      next_s.sdoEn = 1'h0;
      next_s.gapCnt = MIN_GAP_EDGES;
      next_s.pendStart = 1'h1;
      next_s.pendWrite = 1'h0;
      next_s.pendLen = BUSY_RESET_LEN;
    end
    else
    begin
      case (s.phase)
        PH_IDLE:
        begin
          next_s.sdoEn = 1'h0;
          if (rise && s.gapCnt != MIN_GAP_EDGES)
          begin
            next_s.gapCnt = s.gapCnt + 2'h1;
          end
          if (!csHigh)
          begin
            // Select: drive the read/write position low first, then the echo header
            next_s.phase = PH_SHIFT;
            next_s.bitCnt = 5'h00;
            next_s.frameOk = (s.gapCnt == MIN_GAP_EDGES);
            next_s.sdoEn = 1'h1;
            next_s.sdo = 1'h0;
            next_s.outShift = {s.rdHdr, rdData, 1'h0};
          end
        end
        PH_SHIFT:
        begin
          if (csHigh)
          begin
            next_s.phase = PH_IDLE;
            next_s.sdoEn = 1'h0;
            next_s.gapCnt = 2'h0;
            if (s.frameOk && s.bitCnt == WORD_LEN)
            begin
              next_s.pendStart = 1'h1;
              if (s.inShift[WORD_BITS-1])
              begin
                next_s.rdHdr = s.inShift[WORD_BITS-2:DATA_BITS];
                next_s.pendWrite = 1'h0;
                next_s.pendLen = BUSY_READ_LEN;
              end
              else
              begin
                next_s.wrStrobe = 1'h1;
                next_s.wrAddr = s.inShift[WORD_BITS-2:DATA_BITS];
                next_s.wrData = s.inShift[DATA_BITS-1:0];
                next_s.pendWrite = 1'h1;
                next_s.pendLen = BUSY_WRITE_LEN;
              end
            end
          end
          else if (rise)
          begin
            next_s.inShift = {s.inShift[WORD_BITS-2:0], s.sdiS[1]};
            next_s.sdo = s.outShift[WORD_BITS-1];
            next_s.outShift = {s.outShift[WORD_BITS-2:0], 1'h0};
            if (s.bitCnt != BIT_CNT_TOP)
            begin
              next_s.bitCnt = s.bitCnt + 5'h01;
            end
          end
        end
        default:
        begin
          next_s.phase = PH_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= PORT_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs, all straight from flip-flops
  assign sdo = s.sdo;
  assign sdoEn = s.sdoEn;
  assign busyN = link.busyN;
  assign dacUpdate = link.dacStart;
  assign wrStrobe = s.wrStrobe;
  assign wrAddr = s.wrAddr;
  assign wrData = s.wrData;
  assign rdAddr = s.rdHdr;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_sdo_off_released: assert property ($rose(csHigh) |=> !sdoEn)
    else $error("serial output driven after release");
  a_sdo_edge_launch: assert property (sdoEn && $past(sdoEn) && $changed(sdo) |-> $past(rise))
    else $error("serial output changed without a rising edge");
  a_echo_rw_low: assert property ($rose(sdoEn) |-> sdo == 1'h0)
    else $error("readout read/write position not low");
  a_sdi_on_rise: assert property (s.phase == PH_SHIFT && $past(s.phase) == PH_SHIFT
      && $changed(s.inShift) |-> $past(rise))
    else $error("serial input sampled off the rising edge");
  a_busy_first_edge: assert property (link.start && rise && link.busyN |=> !busyN)
    else $error("busy not asserted on first edge");
  a_write_word_len: assert property (wrStrobe |-> $past(s.bitCnt) == WORD_LEN)
    else $error("write taken with wrong bit count");
  a_reset_sched_busy: assert property (!portUp |=> s.pendStart && s.pendLen == BUSY_RESET_LEN)
    else $error("port reset did not schedule busy");

  c_word_write: cover property (wrStrobe);
  c_read_request: cover property ($changed(rdAddr));

endmodule : serial_port_busy_handshake

// file: tb/host_model.sv
module host_model
  import spi_busy_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sdo,
  input wire logic sdoEn,
  input wire logic busyN,
  output logic sclk,
  output logic csN,
  output logic sdi,
  output logic asyncRstN
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle levels at time zero
  initial
  begin
    sclk <= 1'b0;
    csN <= 1'b1;
    sdi <= 1'b0;
    asyncRstN <= 1'b1;
  end

  // One serial clock period: data set at the fall, sampled before the rise
  task automatic tick(input logic d, output logic so, output logic bz);
    @(posedge sys_clk);
    sclk <= 1'b0;
    sdi <= d;
    repeat (3) @(posedge sys_clk);
    so = sdoEn ? sdo : ~sdo; // Undriven line reads as the wrong bit
    bz = busyN;
    @(posedge sys_clk);
    sclk <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask : tick

  // Stops once a rise finds busy high after at least tail rises, counting rises that find busy low
  task automatic measure(input int tail, output int blen);
    logic so;
    logic bz;
    blen = 0;
    for (int i = 0; i < 40; i++)
    begin
      tick(i[0], so, bz);
      if (bz === 1'b0)
        blen++;
      else if (i >= tail - 1)
        break;
    end
  endtask : measure

  // One framed word, MSB first, with the readout collected on the way
  task automatic frame(input word_t w, input int nbits, input int tail,
                       output word_t rx, output logic en, output int blen);
    logic so;
    logic bz;
    rx = '0;
    @(posedge sys_clk);
    csN <= 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      tick(w[WORD_BITS-1-i], so, bz);
      rx = {rx[WORD_BITS-2:0], so};
    end
    en = sdoEn;
    @(posedge sys_clk);
    csN <= 1'b1;
    measure(tail, blen);
  endtask : frame

  // Port reset pulse, then clocks while the reset busy runs
  task automatic portReset(output int blen);
    @(posedge sys_clk);
    asyncRstN <= 1'b0;
    repeat (4) @(posedge sys_clk);
    asyncRstN <= 1'b1;
    measure(3, blen);
  endtask : portReset
endmodule : host_model

// file: tb/serial_port_busy_handshake_tb_top.sv
`define CHECK_EQ(name, exp, got) \
  begin \
    nTests++; \
    if ((got) !== (exp)) \
    begin \
      errCount++; \
      $display("Error %s expected %h seen %h", name, exp, got); \
    end \
  end

module serial_port_busy_handshake_tb_top
  import spi_busy_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam cycles_t W_LEN = 5'h0d;
  localparam cycles_t R_LEN = 5'h04;
  localparam cycles_t RST_LEN = 5'h07;
  localparam int LIMIT = 10000;

  typedef struct {logic rw; addr_t addr; data_t data; data_t rd; cycles_t len;} row_t;
  row_t rows [5] = '{'{1'b0, 9'h155, 16'ha5c3, 16'h1111, W_LEN},
                     '{1'b1, 9'h0aa, 16'h0000, 16'h2222, R_LEN},
                     '{1'b0, 9'h1ff, 16'hffff, 16'h3333, W_LEN},
                     '{1'b1, 9'h000, 16'h0001, 16'h4444, R_LEN},
                     '{1'b0, 9'h001, 16'h8000, 16'h5555, W_LEN}};

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  data_t rdData = '0;
  logic sclk, csN, sdi, asyncRstN, sdo, sdoEn, busyN, dacUpdate, wrStrobe, en;
  addr_t wrAddr, rdAddr, lastRd = '0, lastWa = '0;
  data_t wrData, lastWd = '0;
  word_t rx;
  int errCount = 0, nTests = 0, cyc = 0, strobes = 0, dacs = 0, dacAt = 0, relAt = 0;
  int blen, n0, d0;
  logic prevBusyN = 1'b1;

  always #50 sys_clk = ~sys_clk;

  serial_port_busy_handshake #(.BUSY_WRITE_LEN(W_LEN), .BUSY_READ_LEN(R_LEN),
    .BUSY_RESET_LEN(RST_LEN)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .sclk(sclk),
    .csN(csN), .sdi(sdi), .async_reset_n(asyncRstN), .rdData(rdData), .sdo(sdo),
    .sdoEn(sdoEn), .busyN(busyN), .dacUpdate(dacUpdate), .wrStrobe(wrStrobe),
    .wrAddr(wrAddr), .wrData(wrData), .rdAddr(rdAddr));

  host_model u_host (.sys_clk(sys_clk), .sdo(sdo), .sdoEn(sdoEn), .busyN(busyN),
    .sclk(sclk), .csN(csN), .sdi(sdi), .asyncRstN(asyncRstN));

  // Prints the counts and the verdict, then stops
  task giveVerdict;
    $display("Checks %0d, errors %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : giveVerdict

  // Pulse counts, update and release moments, and the hang limit
  always @(posedge sys_clk)
  begin
    cyc++;
    if (wrStrobe === 1'b1)
      strobes++;
    if (dacUpdate === 1'b1)
      dacAt = cyc;
    if (dacUpdate === 1'b1)
      dacs++;
    if (busyN === 1'b1 && prevBusyN === 1'b0)
      relAt = cyc;
    prevBusyN = busyN;
    if (cyc == LIMIT)
    begin
      errCount++;
      giveVerdict();
    end
  end

  // Reset, table of ordinary words, then refused frames and a port reset
  initial
  begin
    repeat (5) @(posedge sys_clk);
    `CHECK_EQ("busyN in reset", 1'b1, busyN)
    `CHECK_EQ("sdoEn in reset", 1'b0, sdoEn)
    reset_n <= 1'b1;
    u_host.measure(3, blen);
    `CHECK_EQ("reset busy", int'(RST_LEN), blen)
    for (int i = 0; i < 5; i++)
    begin
      n0 = strobes;
      d0 = dacs;
      @(posedge sys_clk);
      rdData <= rows[i].rd;
      `CHECK_EQ("sdoEn idle", 1'b0, sdoEn)
      u_host.frame({rows[i].rw, rows[i].addr, rows[i].data}, 26, 3, rx, en, blen);
      `CHECK_EQ("readout", {1'b0, lastRd, rows[i].rd}, rx)
      `CHECK_EQ("sdoEn selected", 1'b1, en)
      `CHECK_EQ("busy length", int'(rows[i].len), blen)
      if (rows[i].rw)
        lastRd = rows[i].addr;
      else
      begin
        lastWa = rows[i].addr;
        lastWd = rows[i].data;
        `CHECK_EQ("update lead", 32, relAt - dacAt)
      end
      `CHECK_EQ("rdAddr", lastRd, rdAddr)
      `CHECK_EQ("wrAddr", lastWa, wrAddr)
      `CHECK_EQ("wrData", lastWd, wrData)
      `CHECK_EQ("strobes", n0 + (rows[i].rw ? 0 : 1), strobes)
      `CHECK_EQ("updates", d0 + (rows[i].rw ? 0 : 1), dacs)
    end
    n0 = strobes;
    u_host.frame({1'b0, 9'h0f0, 16'h5a5a}, 25, 2, rx, en, blen);
    `CHECK_EQ("short frame busy", 0, blen)
    u_host.frame({1'b0, 9'h0f0, 16'h5a5a}, 26, 3, rx, en, blen);
    `CHECK_EQ("short gap busy", 0, blen)
    `CHECK_EQ("refused strobes", n0, strobes)
    `CHECK_EQ("wrAddr kept", lastWa, wrAddr)
    u_host.frame({1'b0, 9'h0f0, 16'h5a5a}, 26, 3, rx, en, blen);
    `CHECK_EQ("busy after gap", int'(W_LEN), blen)
    `CHECK_EQ("wrAddr new", 9'h0f0, wrAddr)
    u_host.portReset(blen);
    `CHECK_EQ("port reset busy", int'(RST_LEN), blen)
    // System reset in mid-run with the serial clock left high
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHECK_EQ("busyN in mid reset", 1'b1, busyN)
    reset_n <= 1'b1;
    u_host.measure(3, blen);
    `CHECK_EQ("mid reset busy", int'(RST_LEN), blen)
    giveVerdict();
  end
endmodule : serial_port_busy_handshake_tb_top
